// ==== verilog/mbd_pkg.sv ====
// Package with decode constants and carrier types for the microcore branch decoder
package mbd_pkg;

  localparam int unsigned INSTR_W      = 16;
  localparam int unsigned ADDR_W       = 10;
  localparam int unsigned COND_W       = 6;
  localparam int unsigned OFFS_W       = 5;

  // Opcode fields and their widths
  localparam int unsigned COND_REL_OPC_W = 5;
  localparam int unsigned ID_ABS_OPC_W   = 11;
  localparam int unsigned ID_ABS_TAIL_W  = 3;
  localparam int unsigned ID_REL_OPC_W   = 10;
  localparam logic [COND_REL_OPC_W-1:0] COND_REL_OPC = 5'h00;
  localparam logic [ID_ABS_OPC_W-1:0]   ID_ABS_OPC   = 11'h1cc;
  localparam logic [ID_ABS_TAIL_W-1:0]  ID_ABS_TAIL  = 3'h5;
  localparam logic [ID_REL_OPC_W-1:0]   ID_REL_OPC   = 10'h0bd;

  // Field positions inside the instruction word
  localparam int unsigned COND_REL_OPC_LSB = 11;
  localparam int unsigned ID_ABS_OPC_LSB   = 5;
  localparam int unsigned ID_ABS_TAIL_LSB  = 0;
  localparam int unsigned ID_REL_OPC_LSB   = 6;
  localparam int unsigned SELECTOR_LSB     = 5;
  localparam int unsigned OFFS_LSB         = 0;
  localparam int unsigned ID_ABS_SEL_BIT   = 4;
  localparam int unsigned ID_REL_SEL_BIT   = 5;
  localparam int unsigned JREG_SEL_BIT     = 3;

  // Condition selector base codes
  localparam logic [5:0]  SEL_FLAG_LO  = 6'h00;
  localparam logic [5:0]  SEL_FLAG_HI  = 6'h10;
  localparam logic [5:0]  SEL_TERM_CNT = 6'h20;
  localparam logic [5:0]  SEL_START_LO = 6'h24;
  localparam logic [5:0]  SEL_START_HI = 6'h25;
  localparam logic [5:0]  SEL_SCV_LO   = 6'h26;
  localparam logic [5:0]  SEL_SCS_LO   = 6'h29;
  localparam logic [5:0]  SEL_SCV_HI   = 6'h2c;
  localparam logic [5:0]  SEL_ALU_DONE = 6'h2f;
  localparam logic [5:0]  SEL_BOOST_HI = 6'h30;
  localparam logic [5:0]  SEL_BOOST_LO = 6'h31;
  localparam logic [5:0]  SEL_CUR_HI   = 6'h32;
  localparam logic [5:0]  SEL_CUR_LO   = 6'h38;
  localparam logic [5:0]  SEL_OCUR_HI  = 6'h3e;
  localparam logic [5:0]  SEL_OCUR_LO  = 6'h3f;

  // Reset value and sequential step of the program counter
  localparam logic [ADDR_W-1:0] PC_RESET = 10'h000;
  localparam logic [ADDR_W-1:0] PC_STEP  = 10'h001;

  // Feedback inputs sampled by the condition selector
  typedef struct packed {
    logic [15:0] flags;
    logic [3:0]  terminal_count;
    logic        start;
    logic [2:0]  shortcut_drain_source_fb;
    logic [2:0]  shortcut_source_fb;
    logic        alu_done;
    logic        boost_voltage_high;
    logic [5:0]  current_feedback;
    logic        own_current_feedback;
  } mbd_cond_in_t;

  // Branch decision handed from the decoder to the sequencer
  typedef struct packed {
    logic              is_branch;
    logic              taken;
    logic [ADDR_W-1:0] target;
  } mbd_branch_t;

  // Operand fields split out of the instruction word
  typedef struct packed {
    logic [COND_W-1:0] selector;
    logic [OFFS_W-1:0] offset;
    logic              id_abs_select;
    logic              id_rel_select;
    logic              jump_register_select;
  } mbd_instr_fields_t;

endpackage : mbd_pkg

// ==== verilog/mbd_cond_select.sv ====
// Condition selector multiplexer for the relative conditional branch
module mbd_cond_select (
  input  wire logic [5:0]           i_sel,
  input  wire mbd_pkg::mbd_cond_in_t i_cond,
  output logic                      o_true
);

  // Range compare then index; the whole 6-bit space is mapped
  always_comb
  begin
    o_true = 1'b0;
    if (i_sel < mbd_pkg::SEL_FLAG_HI)
      o_true = ~i_cond.flags[i_sel[3:0]];
    else if (i_sel < mbd_pkg::SEL_TERM_CNT)
      o_true = i_cond.flags[i_sel[3:0]];
    else if (i_sel < mbd_pkg::SEL_START_LO)
      o_true = i_cond.terminal_count[i_sel[1:0]];
    else if (i_sel == mbd_pkg::SEL_START_LO)
      o_true = ~i_cond.start;
    else if (i_sel == mbd_pkg::SEL_START_HI)
      o_true = i_cond.start;
    else if (i_sel < mbd_pkg::SEL_SCS_LO)
      o_true = ~i_cond.shortcut_drain_source_fb[2'(i_sel - mbd_pkg::SEL_SCV_LO)];
    else if (i_sel < mbd_pkg::SEL_SCV_HI)
      o_true = ~i_cond.shortcut_source_fb[2'(i_sel - mbd_pkg::SEL_SCS_LO)];
    else if (i_sel < mbd_pkg::SEL_ALU_DONE)
      o_true = i_cond.shortcut_drain_source_fb[2'(i_sel - mbd_pkg::SEL_SCV_HI)];
    else if (i_sel == mbd_pkg::SEL_ALU_DONE)
      o_true = i_cond.alu_done;
    else if (i_sel == mbd_pkg::SEL_BOOST_HI)
      o_true = i_cond.boost_voltage_high;
    else if (i_sel == mbd_pkg::SEL_BOOST_LO)
      o_true = ~i_cond.boost_voltage_high;
    else if (i_sel < mbd_pkg::SEL_CUR_LO)
      o_true = i_cond.current_feedback[3'(i_sel - mbd_pkg::SEL_CUR_HI)];
    else if (i_sel < mbd_pkg::SEL_OCUR_HI)
      o_true = ~i_cond.current_feedback[3'(i_sel - mbd_pkg::SEL_CUR_LO)];
    else if (i_sel == mbd_pkg::SEL_OCUR_HI)
      o_true = i_cond.own_current_feedback;
    else
      o_true = ~i_cond.own_current_feedback;
  end

endmodule : mbd_cond_select

// ==== verilog/mbd_branch_decode.sv ====
// Branch decoder and program counter update for one microcore
module mbd_branch_decode (
  input  wire logic                           i_mclk,
  input  wire logic                           i_rst_n,
  input  wire logic                           i_instr_valid,
  input  wire logic [mbd_pkg::INSTR_W-1:0]    i_instr,
  input  wire logic                           i_core_id,
  input  wire logic [mbd_pkg::ADDR_W-1:0]     i_jump_register_set_0,
  input  wire logic [mbd_pkg::ADDR_W-1:0]     i_jump_register_set_1,
  input  wire mbd_pkg::mbd_cond_in_t          i_cond,
  output logic [mbd_pkg::ADDR_W-1:0]          o_core_program_counter,
  output logic                                o_branch_taken,
  output logic                                o_branch_decoded
);

  // Timing: the instruction at the program counter is presented with i_instr_valid
  // and executes at the next rising edge; the counter and the branch report change
  // at that edge, so the report stands for exactly one cycle after the instruction
  // Limitation: only the three identity and condition forms are branches here;
  // every other opcode simply steps to the next code address

  // Program counter and the registered branch report
  logic [mbd_pkg::ADDR_W-1:0]  core_program_counter_q;
  logic [mbd_pkg::ADDR_W-1:0]  core_program_counter_d;
  logic                        taken_q;
  logic                        taken_d;
  logic                        decoded_q;
  logic                        decoded_d;

  // Operand fields and opcode matches of the three handled forms
  mbd_pkg::mbd_instr_fields_t  fields;
  logic                        is_cond_rel;
  logic                        is_id_abs;
  logic                        is_id_rel;
  logic                        cond_true;

  // Identity test
  logic                        first_core_test;
  logic                        second_core_test;
  logic                        core_identity_select;
  logic                        identity_hit;

  // Targets: relative, absolute and the sequential step
  logic [mbd_pkg::ADDR_W-1:0]  offset_ext;
  logic [mbd_pkg::ADDR_W-1:0]  rel_target;
  logic [mbd_pkg::ADDR_W-1:0]  abs_target;
  logic [mbd_pkg::ADDR_W-1:0]  seq_target;

  // One decision per form, then the merged decision
  mbd_pkg::mbd_branch_t        cond_rel_branch;
  mbd_pkg::mbd_branch_t        id_abs_branch;
  mbd_pkg::mbd_branch_t        id_rel_branch;
  mbd_pkg::mbd_branch_t        branch;

  // Operand fields; each form keeps its operands at fixed bit positions
  // Both relative forms share the offset in the low five bits
  always_comb
  begin
    fields.selector             = i_instr[mbd_pkg::SELECTOR_LSB +: mbd_pkg::COND_W];
    fields.offset               = i_instr[mbd_pkg::OFFS_LSB +: mbd_pkg::OFFS_W];
    fields.id_abs_select        = i_instr[mbd_pkg::ID_ABS_SEL_BIT];
    fields.id_rel_select        = i_instr[mbd_pkg::ID_REL_SEL_BIT];
    fields.jump_register_select = i_instr[mbd_pkg::JREG_SEL_BIT];
  end

  // Opcode matches; the patterns are disjoint, so no priority is implied
  // A near-miss opcode matches none of them and is treated as a plain instruction
  assign is_cond_rel = (i_instr[mbd_pkg::COND_REL_OPC_LSB +: mbd_pkg::COND_REL_OPC_W]
                        == mbd_pkg::COND_REL_OPC);
  assign is_id_abs   = (i_instr[mbd_pkg::ID_ABS_OPC_LSB +: mbd_pkg::ID_ABS_OPC_W]
                        == mbd_pkg::ID_ABS_OPC) &&
                       (i_instr[mbd_pkg::ID_ABS_TAIL_LSB +: mbd_pkg::ID_ABS_TAIL_W]
                        == mbd_pkg::ID_ABS_TAIL);
  assign is_id_rel   = (i_instr[mbd_pkg::ID_REL_OPC_LSB +: mbd_pkg::ID_REL_OPC_W]
                        == mbd_pkg::ID_REL_OPC);

  // Identity selector sits at a different bit in the absolute and relative forms
  assign core_identity_select = is_id_abs ? fields.id_abs_select
                                          : fields.id_rel_select;

  // Core 0 and core 1 tests; for a given core at most one of them can hold
  assign first_core_test  = ~core_identity_select & ~i_core_id;
  assign second_core_test = core_identity_select & i_core_id;
  assign identity_hit     = first_core_test | second_core_test;

  // Sign extension of the offset, one generated bit at a time
  // The top offset bit is the sign and fills every upper address bit
  genvar gi;
  generate
    for (gi = 0; gi < mbd_pkg::ADDR_W; gi++)
    begin : g_offset_ext
      if (gi < mbd_pkg::OFFS_W)
      begin : g_low
        assign offset_ext[gi] = fields.offset[gi];
      end
      else
      begin : g_sign
        assign offset_ext[gi] = fields.offset[mbd_pkg::OFFS_W-1];
      end
    end
  endgenerate

  // The relative sum wraps modulo the code memory size, so a branch near 0 lands near the top
  // Jump registers hold full code addresses, so any location is reachable
  assign rel_target = core_program_counter_q + offset_ext;
  assign abs_target = fields.jump_register_select ? i_jump_register_set_1
                                                  : i_jump_register_set_0;
  assign seq_target = core_program_counter_q + mbd_pkg::PC_STEP;

  // Condition selector; its answer only counts for the conditional relative form
  mbd_cond_select u_cond_select (
    .i_sel  (fields.selector),
    .i_cond (i_cond),
    .o_true (cond_true)
  );

  // Conditional relative form
  // Taken when the selected condition is true
  always_comb
  begin
    cond_rel_branch.is_branch = is_cond_rel;
    cond_rel_branch.taken     = is_cond_rel & cond_true;
    cond_rel_branch.target    = rel_target;
  end

  // Absolute form on identity
  // Taken when the identity selector names this core
  always_comb
  begin
    id_abs_branch.is_branch = is_id_abs;
    id_abs_branch.taken     = is_id_abs & identity_hit;
    id_abs_branch.target    = abs_target;
  end

  // Relative form on identity
  // Same identity test, relative target
  always_comb
  begin
    id_rel_branch.is_branch = is_id_rel;
    id_rel_branch.taken     = is_id_rel & identity_hit;
    id_rel_branch.target    = rel_target;
  end

  // Merge; a cycle without a valid instruction never reports a branch
  // Keeping one decision per form costs a few gates but keeps each form readable
  always_comb
  begin
    branch.is_branch = 1'b0;
    branch.taken     = 1'b0;
    branch.target    = seq_target;
    if (cond_rel_branch.is_branch)
      branch = cond_rel_branch;
    else if (id_abs_branch.is_branch)
      branch = id_abs_branch;
    else if (id_rel_branch.is_branch)
      branch = id_rel_branch;
    if (!i_instr_valid)
    begin
      branch.is_branch = 1'b0;
      branch.taken     = 1'b0;
    end
  end

  // Next program counter; holds when no instruction is presented
  // An untaken branch steps exactly like any other instruction
  always_comb
  begin
    core_program_counter_d = core_program_counter_q;
    taken_d                = branch.taken;
    decoded_d              = branch.is_branch;
    if (i_instr_valid)
    begin
      if (branch.taken)
        core_program_counter_d = branch.target;
      else
        core_program_counter_d = seq_target;
    end
  end

  // State registers, synchronous reset
  // Reset restarts the core at code address 0 and drops any instruction in flight
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
    begin
      core_program_counter_q <= mbd_pkg::PC_RESET;
      taken_q                <= 1'b0;
      decoded_q              <= 1'b0;
    end
    else
    begin
      core_program_counter_q <= core_program_counter_d;
      taken_q                <= taken_d;
      decoded_q              <= decoded_d;
    end
  end

  // Outputs straight from flip-flops
  assign o_core_program_counter = core_program_counter_q;
  assign o_branch_taken         = taken_q;
  assign o_branch_decoded       = decoded_q;

endmodule : mbd_branch_decode

// ==== tb/mbd_branch_decode_chk.sv ====
// Checker of branch decode targets and conditions at the decoder ports
module mbd_branch_decode_chk (
  input wire logic                  i_mclk,
  input wire logic                  i_rst_n,
  input wire logic                  i_instr_valid,
  input wire logic [15:0]           i_instr,
  input wire logic                  i_core_id,
  input wire logic [9:0]            i_jump_register_set_0,
  input wire logic [9:0]            i_jump_register_set_1,
  input wire mbd_pkg::mbd_cond_in_t i_cond,
  input wire logic [9:0]            o_core_program_counter,
  input wire logic                  o_branch_taken,
  input wire logic                  o_branch_decoded
);
  logic       rel, far, rel_id, hit_id, hit_flag, hit_start, hit_own;
  logic [9:0] rel_tgt, far_tgt;
  // Decode recomputed here so a slip in the decoder cannot hide behind itself
  assign rel = i_instr_valid && (i_instr[15:11] == 5'h00);
  assign far = i_instr_valid && (i_instr[15:5] == 11'h1cc) && (i_instr[2:0] == 3'h5);
  assign rel_id = i_instr_valid && (i_instr[15:6] == 10'h0bd);
  assign hit_id = (i_instr[5] == i_core_id);
  assign rel_tgt = o_core_program_counter + {{5{i_instr[4]}}, i_instr[4:0]};
  assign far_tgt = i_instr[3] ? i_jump_register_set_1 : i_jump_register_set_0;
  assign hit_flag = (i_cond.flags[i_instr[8:5]] == i_instr[9]);
  assign hit_start = (i_cond.start == i_instr[5]);
  assign hit_own = i_cond.own_current_feedback ^ i_instr[5];
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  sequence s_rel; rel || rel_id; endsequence
  sequence s_far_hit; far && (i_instr[4] == i_core_id); endsequence
  sequence s_far_miss; far && (i_instr[4] != i_core_id); endsequence
  property p_rel_dec; rel |=> o_branch_decoded; endproperty
  property p_rel_pc; s_rel |=> o_core_program_counter ==
    (o_branch_taken ? $past(rel_tgt) : $past(o_core_program_counter) + 10'h001); endproperty
  property p_flag; rel && !i_instr[10] |=> o_branch_taken == $past(hit_flag); endproperty
  property p_start; rel && (i_instr[10:6] == 5'h12) |=> o_branch_taken == $past(hit_start); endproperty
  property p_own; rel && (i_instr[10:6] == 5'h1f) |=> o_branch_taken == $past(hit_own); endproperty
  property p_far; s_far_hit |=> o_branch_taken && (o_core_program_counter == $past(far_tgt)); endproperty
  property p_far_miss; s_far_miss |=> !o_branch_taken && o_branch_decoded; endproperty
  property p_id; rel_id |=> o_branch_taken == $past(hit_id); endproperty
  a_rel_dec: assert property (p_rel_dec) else $error("relative branch not decoded");
  a_rel_pc: assert property (p_rel_pc) else $error("relative target wrong");
  a_flag: assert property (p_flag) else $error("flag condition wrong");
  a_start: assert property (p_start) else $error("start condition wrong");
  a_own: assert property (p_own) else $error("own feedback condition wrong");
  a_far: assert property (p_far) else $error("far target wrong");
  a_far_miss: assert property (p_far_miss) else $error("far branch taken wrongly");
  a_id: assert property (p_id) else $error("identity condition wrong");
endmodule : mbd_branch_decode_chk
bind mbd_branch_decode mbd_branch_decode_chk u_chk (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
  .i_instr_valid(i_instr_valid), .i_instr(i_instr), .i_core_id(i_core_id),
  .i_jump_register_set_0(i_jump_register_set_0), .i_jump_register_set_1(i_jump_register_set_1),
  .i_cond(i_cond), .o_core_program_counter(o_core_program_counter),
  .o_branch_taken(o_branch_taken), .o_branch_decoded(o_branch_decoded));

// ==== tb/mbd_branch_decode_tb.sv ====
// Self-checking bench for the microcore branch decoder
module mbd_branch_decode_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic                  i_mclk = 1'b0;
  logic                  i_rst_n = 1'b0;
  logic                  i_instr_valid = 1'b0;
  logic [15:0]           i_instr = 16'h0000;
  logic                  i_core_id = 1'b0;
  logic [9:0]            i_jump_register_set_0 = 10'h3ff;
  logic [9:0]            i_jump_register_set_1 = 10'h155;
  mbd_pkg::mbd_cond_in_t i_cond = 36'h0_0000_0000;
  logic [9:0]            o_core_program_counter;
  logic                  o_branch_taken;
  logic                  o_branch_decoded;
  logic [9:0]            pc = 10'h000;
  int                    miscompares = 0;
  int                    check_count = 0;
  int                    cycles = 0;
  mbd_branch_decode u_dut (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_instr_valid(i_instr_valid),
    .i_instr(i_instr), .i_core_id(i_core_id), .i_jump_register_set_0(i_jump_register_set_0),
    .i_jump_register_set_1(i_jump_register_set_1), .i_cond(i_cond),
    .o_core_program_counter(o_core_program_counter), .o_branch_taken(o_branch_taken),
    .o_branch_decoded(o_branch_decoded));
  always #50 i_mclk = ~i_mclk;
  // Watchdog: the whole run needs well under a thousand cycles
  always @(posedge i_mclk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      miscompares++;
      end_of_test();
    end
  end
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk
  function automatic logic [11:0] obs();
    return {o_branch_decoded, o_branch_taken, o_core_program_counter};
  endfunction : obs
  // One executed instruction; the bench keeps its own program counter
  task automatic step(input logic [15:0] ins, input logic [9:0] nxt);
    i_instr = ins;
    i_instr_valid = 1'b1;
    @(posedge i_mclk);
    #10;
    pc = nxt;
  endtask : step
  function automatic logic cond_exp(input logic [5:0] s, input mbd_pkg::mbd_cond_in_t c);
    int i;
    i = s;
    if (i < 32) return c.flags[s[3:0]] == s[4];
    if (i < 36) return c.terminal_count[s[1:0]];
    if (i < 38) return c.start == s[0];
    if (i < 41) return !c.shortcut_drain_source_fb[i-38];
    if (i < 44) return !c.shortcut_source_fb[i-41];
    if (i < 47) return c.shortcut_drain_source_fb[i-44];
    if (i == 47) return c.alu_done;
    if (i < 50) return c.boost_voltage_high == !s[0];
    if (i < 56) return c.current_feedback[i-50];
    if (i < 62) return !c.current_feedback[i-56];
    return c.own_current_feedback == !s[0];
  endfunction : cond_exp
  // Every selector under four input patterns, offsets sweeping -16..15
  task automatic t_cond;
    logic [35:0] pat [4] = '{36'h0_0000_0000, 36'hf_ffff_ffff, 36'h5_5555_5555, 36'ha_aaaa_aaaa};
    logic [5:0]  s;
    logic        tk;
    for (int p = 0; p < 4; p++)
    begin
      for (int k = 0; k < 64; k++)
      begin
        s = k[5:0];
        i_cond = pat[p];
        tk = cond_exp(s, pat[p]);
        step({5'h00, s, s[4:0]}, tk ? pc + {{5{s[4]}}, s[4:0]} : pc + 10'h001);
        chk(obs(), {1'b1, tk, pc});
      end
    end
  endtask : t_cond
  // Both cores, both identity selects, both jump registers
  task automatic t_far;
    logic hit;
    for (int k = 0; k < 8; k++)
    begin
      i_core_id = k[2];
      hit = k[0] == k[2];
      step({11'h1cc, k[0], k[1], 3'h5}, hit ? (k[1] ? i_jump_register_set_1 : i_jump_register_set_0) : pc + 10'h001);
      chk(obs(), {1'b1, hit, pc});
    end
  endtask : t_far
  // Relative identity branch at both offset extremes
  task automatic t_rel_id;
    logic       hit;
    logic [4:0] off;
    for (int k = 0; k < 8; k++)
    begin
      i_core_id = k[2];
      hit = k[0] == k[2];
      off = k[1] ? 5'h10 : 5'h0f;
      step({10'h0bd, k[0], off}, hit ? pc + {{5{off[4]}}, off} : pc + 10'h001);
      chk(obs(), {1'b1, hit, pc});
    end
  endtask : t_rel_id
  // Near-miss opcode is no branch; an idle cycle leaves the counter alone
  task automatic t_idle;
    step(16'h0800, pc + 10'h001);
    chk(obs(), {2'b00, pc});
    i_instr_valid = 1'b0;
    @(posedge i_mclk);
    #10;
    chk(obs(), {2'b00, pc});
  endtask : t_idle
  initial
  begin
    repeat (20) @(posedge i_mclk);
    #10;
    i_rst_n = 1'b1;
    t_cond();
    t_far();
    t_rel_id();
    t_idle();
    end_of_test();
  end
endmodule : mbd_branch_decode_tb
